//--- logic/t1jl_line_init.sv
/*
 * t1jl_line_init: APB register file, T1/J1/E1 mode selection, line
 * encoder and decoder (AMI, AMI with bit 7 stuffing, B8ZS, NRZ) and
 * loss-of-signal detection and recovery with interrupts.
 * Assumes line_tick is a one-clock strobe per line bit, synchronous
 * to clock, and that all inputs are synchronous to clock.
 */
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ns
module t1jl_line_init
(
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// line bit strobe
	input wire logic line_tick,
	// receive line
	input wire logic rx_pos,
	input wire logic rx_neg,
	output logic rx_data,
	output logic rx_data_valid,
	// transmit channel bytes
	input wire logic [7:0] tx_byte,
	input wire logic tx_byte_valid,
	output logic tx_byte_ready,
	// transmit line
	output logic tx_pos,
	output logic tx_neg,
	// mode and status
	output logic e1_mode,
	output logic j1_mode,
	output logic [7:0] master_clock_cfg,
	output logic loss_of_signal,
	output logic irq
);
	typedef enum logic {T1JL_WATCH, T1JL_LOST} t1jl_los_e;

	// whole block state
	typedef struct packed {
		logic primary_mode_bit;  // 0 selects E1
		logic [1:0] line_code;  // t1jl_code_e
		logic digital_if;  // digital rather than analog line
		logic single_rail;  // single rail digital form
		logic precode;  // B8ZS precoding on single rail
		logic japan_variant_select;
		logic [6:0] rx_offset;  // stored, no effect here
		logic [7:0] master_clock_config;
		logic [7:0] loss_detect_count;
		logic [7:0] loss_recover_count;
		logic density_recovery_check;
		logic recovery_irq_enable;
		logic [1:0] irq_stat;
		logic [1:0] irq_en;
		logic [15:0] bpv_cnt;  // bipolar violations seen
		logic [7:0] tx_sh;  // byte being serialised
		logic [2:0] tx_cnt;  // bits left in tx_sh
		logic [15:0] tx_win;  // eight symbols, oldest high
		logic tx_last_pos;  // last mark polarity was positive
		logic tx_p;
		logic tx_n;
		logic [7:0] rx_pul;  // pulse window, oldest high
		logic [7:0] rx_vio;  // violation flags for the window
		logic rx_last_pos;
		logic rx_d;
		logic rx_v;
		t1jl_los_e los_st;
		logic [12:0] zero_run;  // current run of zeros
		logic [12:0] win_cnt;  // bits in recovery interval
		logic [8:0] ones_cnt;  // ones in recovery interval
		logic long_zero_seen;  // density run seen in interval
	} t1jl_state_s;

	t1jl_state_s q_r;  // registered state
	t1jl_state_s q_nxt;  // next state

	logic wr_en;  // write strobe, access phase
	logic rd_en;  // read, access phase
	logic addr_ok;  // address is mapped
	logic [1:0] irq_set;  // events this cycle
	logic [1:0] irq_clr;  // software clears this cycle
	logic [12:0] det_thr;  // zeros to declare loss
	logic [8:0] rec_thr;  // ones to recover
	logic b8zs_on;  // B8ZS substitution active
	logic pulse;  // received pulse this bit
	logic [7:0] load_byte;  // next byte after stuffing
	logic tx_bit;
	logic [1:0] sym;
	logic [15:0] win_new;
	logic [7:0] pul_new;
	logic [7:0] vio_new;
	logic [12:0] zr_new;
	logic [12:0] wc_new;
	logic [8:0] on_new;
	logic lz_new;

	// zero-wait slave; only the unmapped answer differs
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign e1_mode = !q_r.primary_mode_bit;
	assign j1_mode = q_r.primary_mode_bit && q_r.japan_variant_select;
	assign master_clock_cfg = q_r.master_clock_config;
	assign loss_of_signal = (q_r.los_st == T1JL_LOST);
	assign tx_pos = q_r.tx_p;
	assign tx_neg = q_r.tx_n;
	assign rx_data = q_r.rx_d;
	assign rx_data_valid = q_r.rx_v;
	// one interrupt level from enabled sticky bits
	assign irq = |(q_r.irq_stat & q_r.irq_en);
	// a new byte is taken only at the bit that starts it
	assign tx_byte_ready = line_tick && (q_r.tx_cnt == 3'h0);

	// interval scales with the programmed count
	assign det_thr = 13'((14'(q_r.loss_detect_count) + 14'h1) << t1jl_pkg::LOS_STEP_SHIFT);
	// recovery needs count plus one ones
	assign rec_thr = 9'(q_r.loss_recover_count) + 9'h1;
	// single rail only substitutes when precoding asked for
	assign b8zs_on = (q_r.line_code == 2'(t1jl_pkg::T1JL_B8ZS))
		&& (!q_r.single_rail || q_r.precode);
	// single rail carries marks on rx_pos only
	assign pulse = q_r.single_rail ? rx_pos : (rx_pos || rx_neg);

	// read mux and address decode
	always_comb
	begin
		prdata = 32'h0000_0000;
		addr_ok = 1'b1;
		if (paddr == t1jl_pkg::OFS_MODE_ONE)
		begin
			prdata[t1jl_pkg::MODE_PRIMARY_BIT] = q_r.primary_mode_bit;
			prdata[t1jl_pkg::MODE_CODE_LSB +: 2] = q_r.line_code;
			prdata[t1jl_pkg::MODE_DIGITAL_BIT] = q_r.digital_if;
			prdata[t1jl_pkg::MODE_SINGLE_BIT] = q_r.single_rail;
			prdata[t1jl_pkg::MODE_PRECODE_BIT] = q_r.precode;
		end
		else if (paddr == t1jl_pkg::OFS_RX_OFFSET)
			prdata[7:0] = {q_r.japan_variant_select, q_r.rx_offset};
		else if (paddr == t1jl_pkg::OFS_MCLK_CFG)
			prdata[7:0] = q_r.master_clock_config;
		else if (paddr == t1jl_pkg::OFS_LOS_DET)
			prdata[7:0] = q_r.loss_detect_count;
		else if (paddr == t1jl_pkg::OFS_LOS_REC)
			prdata[7:0] = q_r.loss_recover_count;
		else if (paddr == t1jl_pkg::OFS_LINE_CTRL)
		begin
			prdata[t1jl_pkg::CTRL_DENSITY_BIT] = q_r.density_recovery_check;
			prdata[t1jl_pkg::CTRL_RECIRQ_BIT] = q_r.recovery_irq_enable;
		end
		else if (paddr == t1jl_pkg::OFS_STATUS)
		begin
			prdata[t1jl_pkg::STAT_LOS_BIT] = loss_of_signal;
			prdata[t1jl_pkg::STAT_J1_BIT] = j1_mode;
			prdata[t1jl_pkg::STAT_E1_BIT] = e1_mode;
		end
		else if (paddr == t1jl_pkg::OFS_IRQ_STAT)
			prdata[1:0] = q_r.irq_stat;
		else if (paddr == t1jl_pkg::OFS_IRQ_EN)
			prdata[1:0] = q_r.irq_en;
		else if (paddr == t1jl_pkg::OFS_BPV_CNT)
			prdata[15:0] = q_r.bpv_cnt;
		// write-only registers read as zero
		else if (paddr == t1jl_pkg::OFS_IRQ_CLR || paddr == t1jl_pkg::OFS_COMMAND
			|| paddr == t1jl_pkg::OFS_CNT_CLR)
			prdata = 32'h0000_0000;
		// unmapped: zero data, error flagged
		else
			addr_ok = 1'b0;
		pslverr = psel && penable && !addr_ok;
	end

	// next-state logic for the whole block
	always_comb
	begin
		q_nxt = q_r;
		q_nxt.rx_v = 1'b0;
		irq_set = 2'b00;
		irq_clr = 2'b00;
		load_byte = tx_byte_valid ? tx_byte : 8'h00;
		tx_bit = 1'b0;
		sym = q_r.tx_win[15:14];
		win_new = q_r.tx_win;
		pul_new = q_r.rx_pul;
		vio_new = q_r.rx_vio;
		zr_new = q_r.zero_run;
		wc_new = q_r.win_cnt;
		on_new = q_r.ones_cnt;
		lz_new = q_r.long_zero_seen;

		// register writes; unmapped addresses change nothing
		if (wr_en)
		begin
			if (paddr == t1jl_pkg::OFS_MODE_ONE)
			begin
				q_nxt.primary_mode_bit = pwdata[t1jl_pkg::MODE_PRIMARY_BIT];
				q_nxt.line_code = pwdata[t1jl_pkg::MODE_CODE_LSB +: 2];
				q_nxt.digital_if = pwdata[t1jl_pkg::MODE_DIGITAL_BIT];
				q_nxt.single_rail = pwdata[t1jl_pkg::MODE_SINGLE_BIT];
				q_nxt.precode = pwdata[t1jl_pkg::MODE_PRECODE_BIT];
			end
			else if (paddr == t1jl_pkg::OFS_RX_OFFSET)
			begin
				q_nxt.japan_variant_select = pwdata[t1jl_pkg::RXOFS_JAPAN_BIT];
				q_nxt.rx_offset = pwdata[6:0];
			end
			else if (paddr == t1jl_pkg::OFS_MCLK_CFG)
				q_nxt.master_clock_config = pwdata[7:0];
			else if (paddr == t1jl_pkg::OFS_LOS_DET)
				q_nxt.loss_detect_count = pwdata[7:0];
			else if (paddr == t1jl_pkg::OFS_LOS_REC)
				q_nxt.loss_recover_count = pwdata[7:0];
			else if (paddr == t1jl_pkg::OFS_LINE_CTRL)
			begin
				q_nxt.density_recovery_check = pwdata[t1jl_pkg::CTRL_DENSITY_BIT];
				q_nxt.recovery_irq_enable = pwdata[t1jl_pkg::CTRL_RECIRQ_BIT];
			end
			else if (paddr == t1jl_pkg::OFS_IRQ_CLR)
				irq_clr = pwdata[1:0];
			else if (paddr == t1jl_pkg::OFS_IRQ_EN)
				q_nxt.irq_en = pwdata[1:0];
			else if (paddr == t1jl_pkg::OFS_CNT_CLR)
				q_nxt.bpv_cnt = 16'h0000;
		end

		// transmit: serialise, stuff, substitute, drive rails
		if (line_tick)
		begin
			if (q_r.tx_cnt == 3'h0)
			begin
				// bit 7 stuffing of an empty byte
				if (q_r.line_code == 2'(t1jl_pkg::T1JL_AMI_STUFF) && load_byte == 8'h00)
					load_byte = t1jl_pkg::STUFF_BYTE;
				tx_bit = load_byte[7];
				q_nxt.tx_sh = {load_byte[6:0], 1'b0};
				q_nxt.tx_cnt = 3'h7;
			end
			else
			begin
				tx_bit = q_r.tx_sh[7];
				q_nxt.tx_sh = {q_r.tx_sh[6:0], 1'b0};
				q_nxt.tx_cnt = q_r.tx_cnt - 3'h1;
			end
			win_new = {q_r.tx_win[13:0], tx_bit ? t1jl_pkg::SYM_MARK : t1jl_pkg::SYM_ZERO};
			if (b8zs_on && win_new == 16'h0000)
				win_new = t1jl_pkg::B8ZS_TX_PATTERN;
			q_nxt.tx_win = win_new;
			q_nxt.tx_p = 1'b0;
			q_nxt.tx_n = 1'b0;
			// digital NRZ and digital single rail use one output
			if ((q_r.line_code == 2'(t1jl_pkg::T1JL_NRZ) && q_r.digital_if)
				|| (q_r.single_rail && q_r.digital_if))
				q_nxt.tx_p = (sym != t1jl_pkg::SYM_ZERO);
			else
			begin
				case (sym)
					t1jl_pkg::SYM_MARK,
					t1jl_pkg::SYM_BIP:
					begin
						// alternate mark inversion
						q_nxt.tx_p = !q_r.tx_last_pos;
						q_nxt.tx_n = q_r.tx_last_pos;
						q_nxt.tx_last_pos = !q_r.tx_last_pos;
					end
					t1jl_pkg::SYM_VIOL:
					begin
						// deliberate repeat of the last polarity
						q_nxt.tx_p = q_r.tx_last_pos;
						q_nxt.tx_n = !q_r.tx_last_pos;
					end
					default:
					begin
						q_nxt.tx_p = 1'b0;
					end
				endcase
			end
		end

		// receive: violation tracking and B8ZS removal
		if (line_tick)
		begin
			pul_new = {q_r.rx_pul[6:0], pulse};
			vio_new = {q_r.rx_vio[6:0], pulse && !q_r.single_rail && (rx_pos == q_r.rx_last_pos)};
			if (pulse && !q_r.single_rail)
				q_nxt.rx_last_pos = rx_pos;
			if (b8zs_on && !q_r.single_rail && pul_new == t1jl_pkg::B8ZS_RX_PULSES
				&& vio_new == t1jl_pkg::B8ZS_RX_VIOLS)
			begin
				pul_new = 8'h00;
				vio_new = 8'h00;
			end
			else if (vio_new[0] && q_r.bpv_cnt != 16'hFFFF)
				q_nxt.bpv_cnt = q_r.bpv_cnt + 16'h1;
			q_nxt.rx_pul = pul_new;
			q_nxt.rx_vio = vio_new;
			q_nxt.rx_d = q_r.rx_pul[7];
			q_nxt.rx_v = 1'b1;
		end

		// loss of signal counts raw line pulses
		if (line_tick)
		begin
			zr_new = pulse ? 13'h0000 : ((q_r.zero_run == 13'h1FFF) ? q_r.zero_run
				: q_r.zero_run + 13'h1);
			q_nxt.zero_run = zr_new;
			case (q_r.los_st)
				T1JL_WATCH:
				begin
					if (zr_new >= det_thr)
					begin
						q_nxt.los_st = T1JL_LOST;
						irq_set[t1jl_pkg::IRQ_LOS_BIT] = 1'b1;
						q_nxt.win_cnt = 13'h0000;
						q_nxt.ones_cnt = 9'h000;
						q_nxt.long_zero_seen = 1'b0;
					end
				end
				T1JL_LOST:
				begin
					wc_new = q_r.win_cnt + 13'h1;
					on_new = pulse ? q_r.ones_cnt + 9'h1 : q_r.ones_cnt;
					// 15 zeros in a row spoil interval
					lz_new = q_r.long_zero_seen || (zr_new >= 13'(t1jl_pkg::DENSITY_ZERO_RUN));
					if (on_new >= rec_thr && !(q_r.density_recovery_check && lz_new))
					begin
						q_nxt.los_st = T1JL_WATCH;
						irq_set[t1jl_pkg::IRQ_REC_BIT] = q_r.recovery_irq_enable;
					end
					// interval over: start counting afresh
					if (wc_new >= det_thr)
					begin
						wc_new = 13'h0000;
						on_new = 9'h000;
						lz_new = 1'b0;
					end
					q_nxt.win_cnt = wc_new;
					q_nxt.ones_cnt = on_new;
					q_nxt.long_zero_seen = lz_new;
				end
				default:
				begin
					q_nxt.los_st = T1JL_WATCH;
				end
			endcase
		end

		// commands; they override tx_win, tx_cnt, the loss state and zero_run of the same cycle
		if (wr_en && paddr == t1jl_pkg::OFS_COMMAND)
		begin
			if (pwdata[t1jl_pkg::CMD_TX_FLUSH_BIT])
			begin
				q_nxt.tx_win = 16'h0000;
				q_nxt.tx_cnt = 3'h0;
			end
			if (pwdata[t1jl_pkg::CMD_LOS_RESTART_BIT])
			begin
				q_nxt.los_st = T1JL_WATCH;
				q_nxt.zero_run = 13'h0000;
			end
		end

		// sticky status: a new event beats a clear
		q_nxt.irq_stat = (q_r.irq_stat & ~irq_clr) | irq_set;
	end

	// state register
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			q_r <= '0;
			q_r.primary_mode_bit <= t1jl_pkg::RST_PRIMARY_MODE;
			q_r.master_clock_config <= t1jl_pkg::RST_MCLK_CFG;
			q_r.loss_detect_count <= t1jl_pkg::RST_LOS_DET;
			q_r.loss_recover_count <= t1jl_pkg::RST_LOS_REC;
			q_r.los_st <= T1JL_WATCH;
		end
		else
			q_r <= q_nxt;
	end
endmodule : t1jl_line_init

//--- logic/t1jl_pkg.sv
/*
 * t1jl_pkg: register map, field positions, reset values and line
 * code encodings of the T1/J1 line set-up and loss-of-signal block.
 * Assumes a 32-bit APB register bus with byte addresses and one
 * line bit strobe per received and transmitted bit.
 */
package t1jl_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_MODE_ONE = 8'h00;  // mode_register_one
	localparam logic [7:0] OFS_RX_OFFSET = 8'h04;  // receive_offset_register
	localparam logic [7:0] OFS_MCLK_CFG = 8'h08;  // master_clock_config
	localparam logic [7:0] OFS_LOS_DET = 8'h0C;  // loss_detect_count
	localparam logic [7:0] OFS_LOS_REC = 8'h10;  // loss_recover_count
	localparam logic [7:0] OFS_LINE_CTRL = 8'h14;  // recovery options
	localparam logic [7:0] OFS_STATUS = 8'h18;  // live state, read only
	localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;  // sticky events, read only
	localparam logic [7:0] OFS_IRQ_CLR = 8'h20;  // write one to clear
	localparam logic [7:0] OFS_IRQ_EN = 8'h24;  // interrupt enables
	localparam logic [7:0] OFS_COMMAND = 8'h28;  // command_register, write only
	localparam logic [7:0] OFS_CNT_CLR = 8'h2C;  // counter_clear_register, write only
	localparam logic [7:0] OFS_BPV_CNT = 8'h30;  // violation count, read only
	// mode_register_one fields
	localparam int MODE_PRIMARY_BIT = 0;
	localparam int MODE_CODE_LSB = 2;
	localparam int MODE_DIGITAL_BIT = 4;
	localparam int MODE_SINGLE_BIT = 5;
	localparam int MODE_PRECODE_BIT = 6;
	// receive_offset_register fields
	localparam int RXOFS_JAPAN_BIT = 7;
	// line control fields
	localparam int CTRL_DENSITY_BIT = 0;
	localparam int CTRL_RECIRQ_BIT = 1;
	// status fields
	localparam int STAT_LOS_BIT = 0;
	localparam int STAT_J1_BIT = 1;
	localparam int STAT_E1_BIT = 2;
	// interrupt bits: loss declared, loss recovered
	localparam int IRQ_LOS_BIT = 0;
	localparam int IRQ_REC_BIT = 1;
	// command bits
	localparam int CMD_TX_FLUSH_BIT = 0;
	localparam int CMD_LOS_RESTART_BIT = 1;
	// reset values
	localparam logic RST_PRIMARY_MODE = 1'b0;
	localparam logic [7:0] RST_LOS_DET = 8'h00;
	localparam logic [7:0] RST_LOS_REC = 8'h00;
	localparam logic [7:0] RST_MCLK_CFG = 8'h00;
	// loss counting: interval is (count + 1) shifted left by this, 16 bits per step
	localparam int LOS_STEP_SHIFT = 4;
	localparam logic [3:0] DENSITY_ZERO_RUN = 4'hF;
	// line codes
	typedef enum logic [1:0] {T1JL_AMI, T1JL_AMI_STUFF, T1JL_B8ZS, T1JL_NRZ} t1jl_code_e;
	// transmit symbols held in the substitution window
	localparam logic [1:0] SYM_ZERO = 2'h0;
	localparam logic [1:0] SYM_MARK = 2'h1;
	localparam logic [1:0] SYM_VIOL = 2'h2;
	localparam logic [1:0] SYM_BIP = 2'h3;
	// 000VB0VB, oldest symbol first
	localparam logic [15:0] B8ZS_TX_PATTERN = 16'h02CB;
	localparam logic [7:0] B8ZS_RX_PULSES = 8'h1B;
	localparam logic [7:0] B8ZS_RX_VIOLS = 8'h12;
	// all-zero byte gets this bit forced for density
	localparam logic [7:0] STUFF_BYTE = 8'h02;
endpackage : t1jl_pkg

//--- testbench/t1jl_line_chk.sv
/* t1jl_line_chk: port-level assertions for the line set-up block.
   assumes it is bound to t1jl_line_init and sees only its ports. */
`timescale 1ns/1ns
module t1jl_line_chk
(
	// clock and reset
	input logic clock,
	input logic nrst,
	// apb
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [7:0] paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic pready,
	input logic pslverr,
	// line
	input logic line_tick,
	input logic rx_pos,
	input logic rx_neg,
	input logic rx_data_valid,
	input logic tx_pos,
	input logic tx_neg,
	// mode and status
	input logic e1_mode,
	input logic j1_mode,
	input logic [7:0] master_clock_cfg,
	input logic loss_of_signal,
	input logic irq
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	logic wr; // completed write
	logic prim_r, jap_r, rec_r; // shadows of mode, japan and recovery enable
	logic [1:0] en_r; // shadow of interrupt enables
	logic [7:0] mclk_r, det_r; // shadows of clock config and detect count
	int zrun_r; // raw zero run seen at the receive rails
	assign wr = psel && penable && pwrite && pready;
	// shadows follow completed host writes; the run counts sampled zero bits
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			prim_r <= 1'b0;
			jap_r <= 1'b0;
			rec_r <= 1'b0;
			en_r <= 2'h0;
			mclk_r <= 8'h00;
			det_r <= 8'h00;
			zrun_r <= 0;
		end
		else
		begin
			if (wr && paddr == t1jl_pkg::OFS_MODE_ONE) prim_r <= pwdata[0];
			if (wr && paddr == t1jl_pkg::OFS_RX_OFFSET) jap_r <= pwdata[7];
			if (wr && paddr == t1jl_pkg::OFS_LINE_CTRL) rec_r <= pwdata[1];
			if (wr && paddr == t1jl_pkg::OFS_IRQ_EN) en_r <= pwdata[1:0];
			if (wr && paddr == t1jl_pkg::OFS_MCLK_CFG) mclk_r <= pwdata[7:0];
			if (wr && paddr == t1jl_pkg::OFS_LOS_DET) det_r <= pwdata[7:0];
			if (line_tick) zrun_r <= (rx_pos || rx_neg) ? 0 : zrun_r + 1;
		end
	end
	a_ready_zero_wait: assert property (psel |-> pready)
		else $error("pready low");
	a_e1_mode_track: assert property (e1_mode == !prim_r)
		else $error("e1_mode wrong");
	a_j1_mode_track: assert property (j1_mode == (prim_r && jap_r))
		else $error("j1_mode wrong");
	a_mclk_cfg_rw: assert property (master_clock_cfg == mclk_r)
		else $error("master_clock_cfg wrong");
	a_wo_read_zero: assert property (psel && penable && !pwrite &&
		(paddr == t1jl_pkg::OFS_COMMAND || paddr == t1jl_pkg::OFS_CNT_CLR)
		|-> prdata == 32'h0 && !pslverr) else $error("write-only read not zero");
	a_unmapped_err: assert property (psel && penable && paddr > t1jl_pkg::OFS_BPV_CNT
		|-> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
	a_loss_zero_run: assert property ($rose(loss_of_signal) |->
		zrun_r == ((int'(det_r) + 1) << t1jl_pkg::LOS_STEP_SHIFT)) else $error("loss run wrong");
	a_tx_rails_excl: assert property (!(tx_pos && tx_neg))
		else $error("both tx rails high");
	a_rx_valid_tick: assert property (rx_data_valid == $past(line_tick))
		else $error("rx_data_valid missing");
	a_irq_on_loss: assert property ($rose(loss_of_signal) && en_r[0] |-> irq)
		else $error("no loss interrupt");
	a_irq_on_rec: assert property ($fell(loss_of_signal) && en_r[1] && rec_r |-> irq)
		else $error("no recovery interrupt");
	c_loss_set: cover property ($rose(loss_of_signal));
	c_loss_clear: cover property ($fell(loss_of_signal));
	c_refused: cover property (psel && penable && pslverr);
endmodule : t1jl_line_chk
bind t1jl_line_init t1jl_line_chk u_chk (.clock(clock), .nrst(nrst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .line_tick(line_tick), .rx_pos(rx_pos),
	.rx_neg(rx_neg), .rx_data_valid(rx_data_valid), .tx_pos(tx_pos), .tx_neg(tx_neg),
	.e1_mode(e1_mode), .j1_mode(j1_mode), .master_clock_cfg(master_clock_cfg),
	.loss_of_signal(loss_of_signal), .irq(irq));

//--- testbench/t1jl_remote.sv
/* t1jl_remote: far line terminal sending ami marks on two rails.
   assumes one clock; bits advance only at its own line_tick. */
`timescale 1ns/1ns
module t1jl_remote
(
	// clock and reset
	input logic clock,
	input logic nrst,
	// pattern: 0 all ones, 1 all zeros, 2 three ones then fifteen zeros
	input logic [1:0] pat,
	// line
	output logic line_tick,
	output logic rx_pos,
	output logic rx_neg,
	// runs of zeros and ones as sampled at the ticks
	output int zrun,
	output int orun
);
	logic pol_r; // polarity of the next mark
	int ph_r; // place in the pattern
	logic one; // next bit is a mark
	assign one = (pat == 2'h0) || (pat == 2'h2 && ph_r < 3);
	// ticks every other clock; a t1 line never idles, so rails always carry a bit
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			line_tick <= 1'b0;
			rx_pos <= 1'b0;
			rx_neg <= 1'b0;
			pol_r <= 1'b1;
			ph_r <= 0;
			zrun <= 0;
			orun <= 0;
		end
		else
		begin
			line_tick <= !line_tick;
			if (line_tick)
			begin
				zrun <= (rx_pos || rx_neg) ? 0 : zrun + 1;
				orun <= (rx_pos || rx_neg) ? orun + 1 : 0;
				rx_pos <= one && pol_r;
				rx_neg <= one && !pol_r;
				pol_r <= one ? !pol_r : pol_r;
				ph_r <= (ph_r == 17) ? 0 : ph_r + 1;
			end
		end
	end
endmodule : t1jl_remote

//--- testbench/testbench.sv
/* testbench: host over apb plus far line terminal around the block.
   assumes t1jl_line_init, its checker and t1jl_remote are compiled. */
`timescale 1ns/1ns
module testbench;
	logic clock, nrst, psel, penable, pwrite, pready, pslverr, err, line_tick, rx_pos, rx_neg;
	logic rx_data, rx_data_valid, tx_byte_valid, tx_byte_ready, tx_pos, tx_neg;
	logic e1_mode, j1_mode, loss_of_signal, irq;
	logic [7:0] paddr, tx_byte, master_clock_cfg;
	logic [31:0] pwdata, prdata, rd, v;
	logic [1:0] pat;
	int zrun, orun, err_total, checked, n, k, i, m;
	// rw registers with their writable masks
	logic [7:0] ofs [4] = '{8'h08, 8'h0C, 8'h10, 8'h24};
	logic [31:0] msk [4] = '{32'hFF, 32'hFF, 32'hFF, 32'h3};
	// line code cases: mode word, channel byte, marks expected in 16 bits
	logic [7:0] mw [7] = '{8'h01, 8'h01, 8'h05, 8'h09, 8'h1D, 8'h19, 8'h35};
	logic [7:0] by [7] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00};
	int mk [7] = '{16, 0, 2, 8, 16, 8, 2};
	t1jl_line_init DUT (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .line_tick(line_tick), .rx_pos(rx_pos), .rx_neg(rx_neg),
		.rx_data(rx_data), .rx_data_valid(rx_data_valid), .tx_byte(tx_byte),
		.tx_byte_valid(tx_byte_valid), .tx_byte_ready(tx_byte_ready), .tx_pos(tx_pos),
		.tx_neg(tx_neg), .e1_mode(e1_mode), .j1_mode(j1_mode),
		.master_clock_cfg(master_clock_cfg), .loss_of_signal(loss_of_signal), .irq(irq));
	t1jl_remote u_far (.clock(clock), .nrst(nrst), .pat(pat), .line_tick(line_tick),
		.rx_pos(rx_pos), .rx_neg(rx_neg), .zrun(zrun), .orun(orun));
	// 125 MHz clock
	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	task test_done;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			$display("Error %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask : chk
	// a bound that ran out ends the run
	task give_up(input string nm);
		$display("Error %s expected answer seen timeout", nm);
		err_total++;
		test_done;
	endtask : give_up
	// one apb transfer; read data and error taken at the edge pready is seen
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		n = 0;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		if (n >= 16) give_up("pready");
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask : apb
	// step past the next line bit, with its updates landed
	task next_tick;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (line_tick !== 1'b1 && n < 8);
		if (n >= 8) give_up("line_tick");
		#1;
	endtask : next_tick
	task wait_los(input logic lv, input int lim);
		for (k = 0; loss_of_signal !== lv && k < lim; k++) next_tick;
		if (loss_of_signal !== lv) give_up("loss_of_signal");
	endtask : wait_los
	initial
	begin
		err_total = 0;
		checked = 0;
		{nrst, psel, penable, pwrite, paddr, pwdata, pat} = '0;
		tx_byte = 8'hFF;
		tx_byte_valid = 1'b1;
		void'($urandom(32'he5bd504b));
		repeat (20) @(posedge clock);
		nrst <= 1'b1;
		chk("e1_mode", 1, e1_mode);
		apb(0, 8'h0C, 0);
		chk("loss_detect_count", 0, rd);
		apb(0, 8'h10, 0);
		chk("loss_recover_count", 0, rd);
		$display("test reset finished");
		// japan select written before the mode bit: any order is legal
		for (i = 0; i < 4; i++)
		begin
			apb(1, 8'h04, {24'h0, i[1], 7'h0});
			apb(1, 8'h00, {31'h0, i[0]});
			chk("e1_mode", !i[0], e1_mode);
			chk("j1_mode", i[0] & i[1], j1_mode);
			apb(0, 8'h18, 0);
			chk("status", {!i[0], i[0] & i[1]}, rd[2:1]);
		end
		$display("test modes finished");
		for (i = 0; i < 12; i++)
		begin
			v = (i == 0) ? 32'hFFFFFFFF : $urandom;
			apb(1, ofs[i % 4], v);
			apb(0, ofs[i % 4], 0);
			chk("rw_reg", v & msk[i % 4], rd);
			if (i % 4 == 0) chk("master_clock_cfg", v[7:0], master_clock_cfg);
		end
		apb(0, 8'h28, 0);
		chk("command_register", 0, {rd[31:1], err});
		apb(0, 8'h2C, 0);
		chk("counter_clear_register", 0, {rd[31:1], err});
		apb(1, 8'h40, 0);
		apb(0, 8'h40, 0);
		chk("unmapped", 1, {rd[30:0], err});
		$display("test registers finished");
		for (i = 0; i < 7; i++)
		begin
			apb(1, 8'h00, {24'h0, mw[i]});
			@(posedge clock);
			tx_byte <= by[i];
			repeat (24) next_tick;
			m = 0;
			repeat (16)
			begin
				next_tick;
				m += int'(tx_pos | tx_neg);
			end
			chk("tx_marks", mk[i], m);
		end
		$display("test line codes finished");
		// dual rail ami, so marks on either rail count as pulses
		apb(1, 8'h00, 32'h01);
		// loss counts and interrupts set up before the line goes to all zeros
		apb(1, 8'h0C, 32'h0A);
		apb(1, 8'h10, 32'h15);
		apb(1, 8'h14, 32'h2);
		apb(1, 8'h24, 32'h2);
		apb(1, 8'h20, 32'h3);
		pat <= 2'h1;
		wait_los(1, 600);
		chk("zero_run", 176, zrun);
		chk("rx_data", 0, rx_data);
		chk("irq_masked", 0, irq);
		apb(0, 8'h1C, 0);
		chk("irq_status", 1, rd);
		apb(1, 8'h24, 32'h3);
		chk("irq", 1, irq);
		apb(1, 8'h20, 32'h1);
		chk("irq_cleared", 0, irq);
		pat <= 2'h0;
		wait_los(0, 200);
		chk("one_run", 22, orun);
		chk("rx_data", 1, rx_data);
		apb(0, 8'h1C, 0);
		chk("irq_status", 2, rd);
		apb(1, 8'h20, 32'h2);
		chk("irq_cleared", 0, irq);
		$display("test loss finished");
		apb(1, 8'h14, 32'h3);
		pat <= 2'h1;
		wait_los(1, 600);
		pat <= 2'h2;
		repeat (400) next_tick;
		chk("loss_held", 1, loss_of_signal);
		apb(1, 8'h20, 32'h3);
		apb(1, 8'h14, 32'h0);
		wait_los(0, 400);
		apb(0, 8'h1C, 0);
		chk("irq_status", 0, rd);
		$display("test density finished");
		test_done;
	end
endmodule : testbench
